// >>> logic/lpsc_pkg.sv
// package of types and constants for the low-power state control block
package lpsc_pkg;

	// ----------------------------------------
	// power states, gray coded along normal -> stop-grant -> sleep -> deep sleep
	// ----------------------------------------
	typedef enum logic [2:0] {
		LPSC_NORMAL = 3'h0,
		LPSC_STOP_GRANT = 3'h1,
		LPSC_SLEEP = 3'h3,
		LPSC_DEEP_SLEEP = 3'h2,
		LPSC_MGMT = 3'h6,
		LPSC_TRIPPED = 3'h7
	} lpsc_state_t;

	// ----------------------------------------
	// bus transaction codes issued as acknowledges
	// ----------------------------------------
	localparam logic [1:0] LPSC_TXN_NONE = 2'h0;
	localparam logic [1:0] LPSC_TXN_STOP_GRANT_ACK = 2'h1;
	localparam logic [1:0] LPSC_TXN_MGMT_ACK = 2'h2;

	// ----------------------------------------
	// widths and reset values
	// ----------------------------------------
	localparam int LPSC_VCODE_W = 6;
	localparam int LPSC_SAVE_W = 8;
	localparam logic [5:0] LPSC_VCODE_RESET = 6'h00;
	localparam logic [7:0] LPSC_SAVE_RESET = 8'h00;
	// entries in the saved-state memory
	localparam int LPSC_SAVE_DEPTH = 4;
	localparam logic [1:0] LPSC_SAVE_SLOT = 2'h0;

	// ----------------------------------------
	// unit clock gates
	// ----------------------------------------
	typedef struct packed {
		logic core;
		logic bus_unit;
		logic intr_ctrl;
		logic pll;
	} lpsc_clk_en_t;

	localparam lpsc_clk_en_t LPSC_CLK_ALL = 4'hf;
	localparam lpsc_clk_en_t LPSC_CLK_STOP_GRANT = 4'h7;
	localparam lpsc_clk_en_t LPSC_CLK_PLL_ONLY = 4'h1;

	// ----------------------------------------
	// request inputs from core logic; the first four active-low, the rest active-high
	// ----------------------------------------
	typedef struct packed {
		logic clock_stop_request_n;
		logic sleep_request_n;
		logic deep_sleep_request_n;
		logic sysmgmt_interrupt_n;
		logic snoop;
		logic intr;
		logic break_event;
		logic mgmt_done;
	} lpsc_req_t;

endpackage

// >>> logic/lpsc_save_mem.sv
// small memory holding the execution state saved on management interrupt entry
`timescale 1ns/100ps
module lpsc_save_mem (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic wr_en_in,
	input wire logic [1:0] addr_in,
	input wire logic [lpsc_pkg::LPSC_SAVE_W-1:0] wr_data_in,
	output logic [lpsc_pkg::LPSC_SAVE_W-1:0] rd_data_out
);
	import lpsc_pkg::*;

	logic [LPSC_SAVE_W-1:0] mem [LPSC_SAVE_DEPTH];

	// ----------------------------------------
	// write port and registered read
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_data_out <= LPSC_SAVE_RESET;
		end else begin
			rd_data_out <= mem[addr_in];
		end
	end

	// storage itself carries no reset
	always_ff @(posedge clock_in) begin
		if (wr_en_in) begin
			mem[addr_in] <= wr_data_in;
		end
	end
endmodule

// >>> logic/lpsc_ctrl.sv
// low-power state sequencer with management entry, overheat trip and voltage code
`timescale 1ns/100ps
module lpsc_ctrl (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire lpsc_pkg::lpsc_req_t req_in,
	input wire logic over_temp_in,
	input wire logic target_ready_n_in,
	input wire logic [lpsc_pkg::LPSC_VCODE_W-1:0] vcode_sel_in,
	input wire logic [lpsc_pkg::LPSC_SAVE_W-1:0] exec_state_in,
	output lpsc_pkg::lpsc_state_t state_out,
	output lpsc_pkg::lpsc_clk_en_t clk_en_out,
	output logic [1:0] txn_out,
	output logic txn_valid_out,
	output logic exec_run_out,
	output logic system_mgmt_mode_out,
	output logic snoop_ack_out,
	output logic intr_ack_out,
	output logic write_data_go_out,
	output logic overheat_trip_n_out,
	output logic overheat_trip_n_oe_out,
	output logic pending_break_out_n_out,
	output logic pending_break_out_n_oe_out,
	output logic [lpsc_pkg::LPSC_VCODE_W-1:0] voltage_code_out,
	output logic voltage_code_oe_out,
	output logic [lpsc_pkg::LPSC_SAVE_W-1:0] saved_state_out
);
	import lpsc_pkg::*;

	// ----------------------------------------
	// whole module state
	// ----------------------------------------
	typedef struct packed {
		logic stop_meta;
		logic stop_sync;
		logic release_seen;
		logic drive_on;
		lpsc_state_t state;
		lpsc_state_t resume;
		lpsc_clk_en_t clk_en;
		logic [1:0] txn;
		logic txn_valid;
		logic exec_run;
		logic mgmt;
		logic snoop_ack;
		logic intr_ack;
		logic wr_go;
		logic trip_n;
		logic brk_n;
		logic [LPSC_VCODE_W-1:0] vcode;
	} lpsc_ctrl_st_t;

	localparam lpsc_ctrl_st_t ST_RESET = '{
		stop_meta: 1'b1, stop_sync: 1'b1, release_seen: 1'b0, drive_on: 1'b1,
		state: LPSC_NORMAL, resume: LPSC_NORMAL, clk_en: LPSC_CLK_ALL,
		txn: LPSC_TXN_NONE, txn_valid: 1'b0, exec_run: 1'b0, mgmt: 1'b0,
		snoop_ack: 1'b0, intr_ack: 1'b0, wr_go: 1'b0, trip_n: 1'b1,
		brk_n: 1'b1, vcode: LPSC_VCODE_RESET
	};

	lpsc_ctrl_st_t st;
	lpsc_ctrl_st_t next_st;
	logic save_wr;

	// clock gate pattern for a given state
	function automatic lpsc_clk_en_t clk_for(input lpsc_state_t s);
		case (s)
			LPSC_STOP_GRANT: clk_for = LPSC_CLK_STOP_GRANT;
			LPSC_SLEEP: clk_for = LPSC_CLK_PLL_ONLY;
			LPSC_DEEP_SLEEP: clk_for = LPSC_CLK_PLL_ONLY;
			LPSC_TRIPPED: clk_for = LPSC_CLK_PLL_ONLY;
			default: clk_for = LPSC_CLK_ALL;
		endcase
	endfunction

	// ----------------------------------------
	// saved execution state
	// ----------------------------------------
	lpsc_save_mem u_save (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.wr_en_in(save_wr),
		.addr_in(LPSC_SAVE_SLOT),
		.wr_data_in(exec_state_in),
		.rd_data_out(saved_state_out)
	);

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		next_st = st;
		save_wr = 1'b0;
		next_st.txn = LPSC_TXN_NONE;
		next_st.txn_valid = 1'b0;
		next_st.snoop_ack = 1'b0;
		next_st.intr_ack = 1'b0;
		// two-flop synchroniser for the clock-stop request
		next_st.stop_meta = req_in.clock_stop_request_n;
		next_st.stop_sync = st.stop_meta;
		// catch the management level once, on the first edge after release
		next_st.release_seen = 1'b1;
		if (!st.release_seen) begin
			next_st.drive_on = req_in.sysmgmt_interrupt_n;
		end
		next_st.vcode = vcode_sel_in;
		case (st.state)
			LPSC_NORMAL: begin
				if (!st.stop_sync) begin
					next_st.state = LPSC_STOP_GRANT;
					next_st.txn = LPSC_TXN_STOP_GRANT_ACK;
					next_st.txn_valid = 1'b1;
				end else if (!req_in.sysmgmt_interrupt_n && st.release_seen) begin
					save_wr = 1'b1;
					next_st.state = LPSC_MGMT;
					next_st.txn = LPSC_TXN_MGMT_ACK;
					next_st.txn_valid = 1'b1;
				end
				next_st.snoop_ack = req_in.snoop;
				next_st.intr_ack = req_in.intr;
			end
			LPSC_STOP_GRANT: begin
				next_st.snoop_ack = req_in.snoop;
				next_st.intr_ack = req_in.intr;
				if (st.stop_sync) begin
					next_st.state = st.resume;
				end else if (!req_in.sleep_request_n) begin
					next_st.state = LPSC_SLEEP;
				end
			end
			LPSC_SLEEP: begin
				// snoops, interrupts and clock-stop are not looked at here
				if (req_in.sleep_request_n) begin
					next_st.state = LPSC_STOP_GRANT;
				end else if (!req_in.deep_sleep_request_n) begin
					next_st.state = LPSC_DEEP_SLEEP;
				end
			end
			LPSC_DEEP_SLEEP: begin
				if (req_in.deep_sleep_request_n) begin
					next_st.state = LPSC_SLEEP;
				end
			end
			LPSC_MGMT: begin
				if (req_in.mgmt_done) begin
					next_st.state = LPSC_NORMAL;
				end else if (!st.stop_sync) begin
					next_st.resume = LPSC_MGMT;
					next_st.state = LPSC_STOP_GRANT;
					next_st.txn = LPSC_TXN_STOP_GRANT_ACK;
					next_st.txn_valid = 1'b1;
				end
				next_st.snoop_ack = req_in.snoop;
				next_st.intr_ack = req_in.intr;
			end
			LPSC_TRIPPED: begin
				next_st.state = LPSC_TRIPPED; // halted until reset
			end
			default: begin
				next_st.state = LPSC_NORMAL;
			end
		endcase
		if (next_st.state == LPSC_NORMAL) begin
			next_st.resume = LPSC_NORMAL;
		end
		// overheat overrides everything and holds till reset; sleep stays deaf to it
		if (over_temp_in && st.state != LPSC_SLEEP) begin
			next_st.state = LPSC_TRIPPED;
			next_st.trip_n = 1'b0;
		end
		next_st.clk_en = clk_for(next_st.state);
		next_st.exec_run = (next_st.state == LPSC_NORMAL) || (next_st.state == LPSC_MGMT);
		next_st.mgmt = (next_st.state == LPSC_MGMT) ||
			(next_st.state != LPSC_NORMAL && next_st.resume == LPSC_MGMT);
		// write data may go only when the target says it is ready
		next_st.wr_go = ~target_ready_n_in & next_st.exec_run;
		// break event latched while clock-stop is held, released with it
		if (st.stop_sync) begin
			next_st.brk_n = 1'b1;
		end else if (req_in.break_event) begin
			next_st.brk_n = 1'b0;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= ST_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs, straight from flops
	// ----------------------------------------
	assign state_out = st.state;
	assign clk_en_out = st.clk_en;
	assign txn_out = st.txn;
	assign txn_valid_out = st.txn_valid;
	assign exec_run_out = st.exec_run;
	assign system_mgmt_mode_out = st.mgmt;
	assign snoop_ack_out = st.snoop_ack;
	assign intr_ack_out = st.intr_ack;
	assign write_data_go_out = st.wr_go;
	assign overheat_trip_n_out = st.trip_n;
	assign pending_break_out_n_out = st.brk_n;
	assign voltage_code_out = st.vcode;
	// enables drop when the management level was held at reset release
	assign overheat_trip_n_oe_out = st.drive_on;
	assign pending_break_out_n_oe_out = st.drive_on;
	assign voltage_code_oe_out = st.drive_on;
endmodule

// >>> testbench/lpsc_ctrl_sva.sv
// concurrent checks on the low-power state controller ports
`timescale 1ns/100ps
module lpsc_ctrl_sva (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire lpsc_pkg::lpsc_req_t req_in,
	input wire logic over_temp_in,
	input wire logic target_ready_n_in,
	input wire lpsc_pkg::lpsc_state_t state_out,
	input wire lpsc_pkg::lpsc_clk_en_t clk_en_out,
	input wire logic [1:0] txn_out,
	input wire logic txn_valid_out,
	input wire logic exec_run_out,
	input wire logic snoop_ack_out,
	input wire logic intr_ack_out,
	input wire logic overheat_trip_n_out,
	input wire logic pending_break_out_n_out,
	input wire logic write_data_go_out
);
	import lpsc_pkg::*;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	a_sleep_clk_gate: assert property (state_out == LPSC_SLEEP |-> clk_en_out == LPSC_CLK_PLL_ONLY)
		else $error("sleep gates");
	a_sleep_no_acks: assert property (state_out == LPSC_SLEEP && $past(state_out) == LPSC_SLEEP
		|-> !snoop_ack_out && !intr_ack_out) else $error("sleep acks");
	a_sleep_holds: assert property (state_out == LPSC_SLEEP && !req_in.sleep_request_n
		&& req_in.deep_sleep_request_n |=> state_out == LPSC_SLEEP) else $error("sleep left");
	a_sleep_exit: assert property (state_out == LPSC_SLEEP && req_in.sleep_request_n
		|=> state_out == LPSC_STOP_GRANT && clk_en_out == LPSC_CLK_STOP_GRANT) else $error("wake");
	a_deep_entry: assert property (state_out == LPSC_SLEEP && !req_in.sleep_request_n
		&& !req_in.deep_sleep_request_n |=> state_out == LPSC_DEEP_SLEEP) else $error("deep");
	a_sleep_entry: assert property (state_out == LPSC_STOP_GRANT && !req_in.sleep_request_n
		&& !over_temp_in && !$past(req_in.clock_stop_request_n, 2)
		|=> state_out == LPSC_SLEEP) else $error("sleep entry");
	a_no_skip_sleep: assert property (state_out == LPSC_NORMAL
		|=> state_out != LPSC_SLEEP && state_out != LPSC_DEEP_SLEEP) else $error("skipped");
	a_stop_latency: assert property (state_out == LPSC_NORMAL && $fell(req_in.clock_stop_request_n)
		##1 !req_in.clock_stop_request_n [*2] |=> state_out == LPSC_STOP_GRANT) else $error("stop");
	a_stop_ack: assert property (state_out == LPSC_STOP_GRANT && $past(state_out) == LPSC_NORMAL
		|-> txn_valid_out && txn_out == LPSC_TXN_STOP_GRANT_ACK) else $error("stop ack");
	a_stop_clocks: assert property (state_out == LPSC_STOP_GRANT
		|-> clk_en_out == LPSC_CLK_STOP_GRANT) else $error("stop gates");
	a_trip_halt: assert property (over_temp_in && state_out == LPSC_NORMAL
		|=> !overheat_trip_n_out && !exec_run_out) else $error("trip");
	a_break_hold: assert property (!pending_break_out_n_out && !req_in.clock_stop_request_n
		&& !$past(req_in.clock_stop_request_n, 2) |=> !pending_break_out_n_out) else $error("break");
	a_write_go: assert property (write_data_go_out ==
		($past(!target_ready_n_in) && exec_run_out)) else $error("write go");
endmodule
bind lpsc_ctrl lpsc_ctrl_sva u_sva (.clock_in(clock_in), .rst_n_in(rst_n_in), .req_in(req_in),
	.over_temp_in(over_temp_in), .target_ready_n_in(target_ready_n_in),
	.state_out(state_out), .clk_en_out(clk_en_out),
	.txn_out(txn_out), .txn_valid_out(txn_valid_out), .exec_run_out(exec_run_out),
	.snoop_ack_out(snoop_ack_out), .intr_ack_out(intr_ack_out),
	.overheat_trip_n_out(overheat_trip_n_out), .pending_break_out_n_out(pending_break_out_n_out),
	.write_data_go_out(write_data_go_out));

// >>> testbench/lpsc_far_side.sv
// far side model: chipset target readiness, test reset and core regulator
`timescale 1ns/100ps
module lpsc_far_side (
	input wire logic rst_n_in,
	input wire logic accept_in,
	input wire logic [5:0] voltage_code_in,
	input wire logic voltage_code_oe_in,
	output logic target_ready_n_out,
	output logic test_reset_n_out,
	output logic [5:0] supplied_code_out,
	output logic supply_on_out
);
	// target ready only while write data can be taken
	assign target_ready_n_out = !(accept_in && rst_n_in);
	// test port reset held low through reset
	assign test_reset_n_out = rst_n_in;
	// regulator supplies the exact code or switches off
	assign supply_on_out = voltage_code_oe_in && rst_n_in;
	assign supplied_code_out = supply_on_out ? voltage_code_in : 6'h00;
endmodule

// >>> testbench/low_power_state_control_test.sv
// self-checking bench for the low-power state controller
`timescale 1ns/100ps
module low_power_state_control_test;
	import lpsc_pkg::*;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	lpsc_req_t req = 8'hf0;
	logic over_temp = 1'b0;
	logic accept = 1'b0;
	logic vok = 1'b0;
	logic [5:0] vsel = 6'h00;
	logic [5:0] pv = 6'h00;
	logic [7:0] exec_st = 8'h00;
	logic [7:0] sv;
	logic trn, tv, run, mm, sack, iack, trip_n, trip_oe, brk_n, brk_oe, voe, son;
	logic wgo, trst_n;
	logic trn_d = 1'b1;
	lpsc_state_t st;
	lpsc_clk_en_t ce;
	logic [1:0] txn;
	logic [5:0] vcode, sup;
	logic [7:0] saved;
	logic [1:0] exp_q[$];
	int miscompares = 0;
	int tests_run = 0;
	always #4 clock_in = ~clock_in;
	lpsc_ctrl DUT (.clock_in(clock_in), .rst_n_in(rst_n_in), .req_in(req), .over_temp_in(over_temp),
		.target_ready_n_in(trn), .vcode_sel_in(vsel), .exec_state_in(exec_st), .state_out(st),
		.clk_en_out(ce), .txn_out(txn), .txn_valid_out(tv), .exec_run_out(run),
		.system_mgmt_mode_out(mm), .snoop_ack_out(sack), .intr_ack_out(iack),
		.write_data_go_out(wgo), .overheat_trip_n_out(trip_n), .overheat_trip_n_oe_out(trip_oe),
		.pending_break_out_n_out(brk_n), .pending_break_out_n_oe_out(brk_oe),
		.voltage_code_out(vcode), .voltage_code_oe_out(voe), .saved_state_out(saved));
	lpsc_far_side far (.rst_n_in(rst_n_in), .accept_in(accept), .voltage_code_in(vcode),
		.voltage_code_oe_in(voe), .target_ready_n_out(trn), .test_reset_n_out(trst_n),
		.supplied_code_out(sup), .supply_on_out(son));
	task automatic chk(input logic [7:0] g, e, input string m);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic go_n(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	task automatic wrap_up;
		// an acknowledge still owed at the end is a miss
		if (exp_q.size() != 0) begin
			miscompares++;
			$display("[ERR] %0t acks missing %0d", $time, exp_q.size());
		end
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// random regulator code, saved state and target readiness
	always @(posedge clock_in) begin
		vsel <= 6'($urandom);
		exec_st <= 8'($urandom);
		accept <= 1'($urandom);
	end
	// result watcher: acks against queued notes, regulator against last code
	always @(posedge clock_in) begin
		if (tv === 1'b1) begin
			if (exp_q.size() == 0) chk(8'(txn), 8'hff, "extra ack");
			else chk(8'(txn), 8'(exp_q.pop_front()), "ack code");
		end
		if (son === 1'b1 && vok) chk(8'(sup), 8'(pv), "vcode");
		if (vok && trn_d === 1'b1) chk(8'(wgo), 8'h00, "write go");
		pv <= vsel;
		trn_d <= trn;
		vok <= rst_n_in;
	end
	// main sequence: each step drives at an edge, then checks the last edge
	initial begin
		void'($urandom(32'h2361748b));
		go_n(3);
		chk(8'(trst_n), 8'h00, "test reset");
		rst_n_in <= 1'b1;
		#1 chk(8'({trip_n, brk_n, voe, trip_oe, ce}), 8'hff, "reset");
		go_n(2);
		req.sleep_request_n <= 1'b0;
		go_n(2);
		req.sleep_request_n <= 1'b1;
		req.clock_stop_request_n <= 1'b0;
		exp_q.push_back(LPSC_TXN_STOP_GRANT_ACK);
		#1 chk(8'(st), 8'(LPSC_NORMAL), "sleep in normal");
		go_n(3);
		req.snoop <= 1'b1;
		req.intr <= 1'b1;
		#1 chk(8'({st, ce, run}), 8'({LPSC_STOP_GRANT, LPSC_CLK_STOP_GRANT, 1'b0}), "sg");
		go_n(1);
		req.break_event <= 1'b1;
		#1 chk(8'({sack, iack}), 8'h03, "sg acks");
		go_n(1);
		req.break_event <= 1'b0;
		req.sleep_request_n <= 1'b0;
		req.sysmgmt_interrupt_n <= 1'b0;
		#1 chk(8'(brk_n), 8'h00, "break");
		go_n(1);
		#1 chk(8'({st, ce}), 8'({LPSC_SLEEP, LPSC_CLK_PLL_ONLY}), "sleep");
		go_n(2);
		req.deep_sleep_request_n <= 1'b0;
		#1 chk(8'({st, sack, iack, brk_n}), 8'({LPSC_SLEEP, 3'h0}), "sleep deaf");
		go_n(1);
		req.deep_sleep_request_n <= 1'b1;
		req.sysmgmt_interrupt_n <= 1'b1;
		req.snoop <= 1'b0;
		req.intr <= 1'b0;
		#1 chk(8'(st), 8'(LPSC_DEEP_SLEEP), "deep");
		go_n(1);
		req.sleep_request_n <= 1'b1;
		go_n(1);
		req.clock_stop_request_n <= 1'b1;
		#1 chk(8'({st, ce, brk_n}), 8'({LPSC_STOP_GRANT, LPSC_CLK_STOP_GRANT, 1'b0}), "wake");
		go_n(4);
		req.sysmgmt_interrupt_n <= 1'b0;
		exp_q.push_back(LPSC_TXN_MGMT_ACK);
		#1 chk(8'({st, ce, brk_n}), 8'({LPSC_NORMAL, LPSC_CLK_ALL, 1'b1}), "resume");
		go_n(1);
		sv = exec_st;
		req.sysmgmt_interrupt_n <= 1'b1;
		#1 chk(8'({st, mm}), 8'({LPSC_MGMT, 1'b1}), "mgmt");
		go_n(2);
		req.mgmt_done <= 1'b1;
		#1 chk(saved, sv, "saved");
		go_n(1);
		req.mgmt_done <= 1'b0;
		go_n(1);
		over_temp <= 1'b1;
		go_n(2);
		over_temp <= 1'b0;
		#1 chk(8'({trip_n, run}), 8'h00, "trip");
		go_n(1);
		rst_n_in <= 1'b0;
		req.sysmgmt_interrupt_n <= 1'b0;
		go_n(2);
		rst_n_in <= 1'b1;
		go_n(2);
		#1 chk(8'({trip_n, trip_oe, brk_oe, voe}), 8'h08, "float");
		wrap_up;
	end
	// watchdog well beyond the sequence length
	initial begin
		#4000;
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up;
	end
endmodule
